// File: src/pioh_pkg.sv
// Package: constants and types for the programmed IO bus master
package pioh_pkg;
   localparam int DATA_W = 24;
   localparam int LEVELS = 24;
   localparam int OP_LSB = 0;
   localparam int OP_MSB = 12;
   localparam int DIR_BIT = 13;
   localparam int ACC_BIT = 14;
   localparam int ADDR_LSB = 16;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TIMEOUT_NS = 16640;
   localparam int TIMEOUT_CYC = (TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
   localparam int SETTLE_CYC = 2;
   localparam logic [23:0] RESET_WORD = 24'h000000;
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_WDATA = 8'h04;
   localparam logic [7:0] ADDR_RDATA = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_CTRL = 8'h10;
   localparam logic [7:0] ADDR_INTREQ = 8'h14;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_REFUSED = 2;
   localparam int ST_TIMEOUT = 3;
   localparam int ST_INTPEND = 4;
   localparam int CTRL_OFFLINE = 0;
   localparam int CTRL_CLEAR = 1;
   typedef enum {
      S_IDLE, S_CMD_SETTLE, S_CMD_WAIT, S_CMD_DROP,
      S_DAT_SETTLE, S_DAT_WAIT, S_DAT_DROP
   } pioh_state_e;
endpackage

// File: src/pioh_timer.sv
// Module: handshake timeout counter
`timescale 1ns/1ps
module pioh_timer
   import pioh_pkg::*;
#(
   parameter int LIMIT = TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic run,
   output logic expired
);
   logic [15:0] count;
   always_ff @(posedge clk) begin
      if (srst || !run) begin
         count <= 16'h0000;
         expired <= 1'b0;
      end else if (count == 16'(LIMIT - 1)) begin
         expired <= 1'b1;
      end else begin
         count <= count + 16'h0001;
      end
   end
endmodule

// File: src/pioh_intmask.sv
// Module: interrupt line gating and pending detect
`timescale 1ns/1ps
module pioh_intmask
   import pioh_pkg::*;
#(
   parameter int N = LEVELS
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic offline,
   input wire logic [N-1:0] lines,
   output logic [N-1:0] gated,
   output logic pending
);
   always_ff @(posedge clk) begin
      if (srst) begin
         gated <= '0;
         pending <= 1'b0;
      end else begin
         gated <= offline ? '0 : lines;
         pending <= !offline && (|lines);
      end
   end
endmodule

// File: src/pioh_master.sv
// Module: processor end of the programmed IO bus, APB register slave
// Notes on behaviour
// - Command on bus, then command strobe
// - Output strobe only after data settles
// - Input strobe asks synchronizer to drive
// - Refusal sampled only in command cycles
// - Interlocked exchange, each strobe answered
// - Data exchange only after command acknowledged
// - Opcode bits 0-12, address from 16
// - Bit 13 direction, ignored without 14
// - Bit 14 selects data exchange
// - One 24-bit word, unused bits zero
// - Unanswered command aborts after 16.64 us
// - System clear resets all control state; here the offline bit and interrupt gating are kept
// - Offline line blocks all interrupts
// - Requests examined at fetch end
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module pioh_master
   import pioh_pkg::*;
#(
   parameter int W = DATA_W,
   parameter int N = LEVELS,
   parameter int TIMEOUT = TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [W-1:0] busIn,
   output logic [W-1:0] busOut,
   output logic busOe,
   output logic commandStrobe,
   output logic dataOutputAvailable,
   output logic dataInputRequest,
   input wire logic acknowledge,
   input wire logic commandRefused,
   input wire logic [N-1:0] interruptRequestLine,
   output logic systemClear,
   output logic offlineInhibit,
   output logic interruptPending
);
   pioh_state_e state;
   logic [W-1:0] cmdWord;
   logic [W-1:0] outWord;
   logic [W-1:0] inWord;
   logic busy;
   logic done;
   logic refused;
   logic timedOut;
   logic offline;
   logic [1:0] settle;
   logic tmrRun;
   logic expired;
   logic [N-1:0] gatedLines;
   logic pendingRaw;
   logic wrEn;
   logic rdEn;
   logic startReq;
   logic [31:0] statusWord;
   logic [31:0] ctrlWord;

   function automatic logic known_addr(input logic [7:0] a);
      case (a)
         ADDR_CMD, ADDR_WDATA, ADDR_RDATA,
         ADDR_STATUS, ADDR_CTRL, ADDR_INTREQ: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   assign wrEn = psel && penable && pwrite && pready;
   // Read data is loaded in the first access cycle, ahead of ready
   assign rdEn = psel && penable && !pwrite && !pready;

   // Status flags packed for software
   always_comb begin
      statusWord = 32'h00000000;
      statusWord[ST_BUSY] = busy;
      statusWord[ST_DONE] = done;
      statusWord[ST_REFUSED] = refused;
      statusWord[ST_TIMEOUT] = timedOut;
      statusWord[ST_INTPEND] = interruptPending;
   end

   always_comb begin
      ctrlWord = 32'h00000000;
      ctrlWord[CTRL_OFFLINE] = offline;
      ctrlWord[CTRL_CLEAR] = systemClear;
   end
   assign startReq = wrEn && paddr == ADDR_CMD && state == S_IDLE;
   assign tmrRun = state == S_CMD_WAIT || state == S_DAT_WAIT;

   pioh_timer #(.LIMIT(TIMEOUT)) u_timer (
      .clk(clk),
      .srst(srst || systemClear),
      .run(tmrRun),
      .expired(expired)
   );

   pioh_intmask #(.N(N)) u_intmask (
      .clk(clk),
      .srst(srst),
      .offline(offline),
      .lines(interruptRequestLine),
      .gated(gatedLines),
      .pending(pendingRaw)
   );

   // One-cycle-late ready gives a fixed two-cycle access
   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && penable && !pready && !known_addr(paddr);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h00000000;
      end else if (rdEn) begin
         case (paddr)
            ADDR_CMD: prdata <= {8'h00, cmdWord};
            ADDR_WDATA: prdata <= {8'h00, outWord};
            ADDR_RDATA: prdata <= {8'h00, inWord};
            ADDR_STATUS: prdata <= statusWord;
            ADDR_CTRL: prdata <= ctrlWord;
            ADDR_INTREQ: prdata <= {8'h00, gatedLines};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         offline <= 1'b0;
         systemClear <= 1'b0;
      end else if (wrEn && paddr == ADDR_CTRL) begin
         offline <= pwdata[CTRL_OFFLINE];
         systemClear <= pwdata[CTRL_CLEAR];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         offlineInhibit <= 1'b0;
         interruptPending <= 1'b0;
      end else begin
         offlineInhibit <= offline;
         interruptPending <= pendingRaw;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || systemClear) begin
         outWord <= RESET_WORD;
      end else if (wrEn && paddr == ADDR_WDATA) begin
         outWord <= pwdata[W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst || systemClear) begin
         cmdWord <= RESET_WORD;
      end else if (startReq) begin
         cmdWord <= pwdata[W-1:0];
      end
   end

   // Exchange sequencer
   always_ff @(posedge clk) begin
      if (srst || systemClear) begin
         state <= S_IDLE;
         settle <= 2'b00;
         busOut <= RESET_WORD;
         busOe <= 1'b0;
         commandStrobe <= 1'b0;
         dataOutputAvailable <= 1'b0;
         dataInputRequest <= 1'b0;
         inWord <= RESET_WORD;
         busy <= 1'b0;
         done <= 1'b0;
         refused <= 1'b0;
         timedOut <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (startReq) begin
                  busOut <= pwdata[W-1:0];
                  busOe <= 1'b1;
                  settle <= 2'(SETTLE_CYC - 1);
                  busy <= 1'b1;
                  done <= 1'b0;
                  refused <= 1'b0;
                  timedOut <= 1'b0;
                  state <= S_CMD_SETTLE;
               end
            end
            S_CMD_SETTLE: begin
               if (settle == 2'b00) begin
                  commandStrobe <= 1'b1;
                  state <= S_CMD_WAIT;
               end else begin
                  settle <= settle - 2'b01;
               end
            end
            S_CMD_WAIT: begin
               if (acknowledge) begin
                  commandStrobe <= 1'b0;
                  busOe <= 1'b0;
                  refused <= commandRefused;
                  state <= S_CMD_DROP;
               end else if (expired) begin
                  commandStrobe <= 1'b0;
                  busOe <= 1'b0;
                  timedOut <= 1'b1;
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= S_IDLE;
               end
            end
            S_CMD_DROP: begin
               // Wait for acknowledge removal before reusing the lines
               if (!acknowledge) begin
                  if (refused || !cmdWord[ACC_BIT]) begin
                     busy <= 1'b0;
                     done <= 1'b1;
                     state <= S_IDLE;
                  end else begin
                     busOut <= outWord;
                     busOe <= !cmdWord[DIR_BIT];
                     settle <= 2'(SETTLE_CYC - 1);
                     state <= S_DAT_SETTLE;
                  end
               end
            end
            S_DAT_SETTLE: begin
               if (settle == 2'b00) begin
                  dataOutputAvailable <= !cmdWord[DIR_BIT];
                  dataInputRequest <= cmdWord[DIR_BIT];
                  state <= S_DAT_WAIT;
               end else begin
                  settle <= settle - 2'b01;
               end
            end
            S_DAT_WAIT: begin
               // Refusal ignored in data cycles
               if (acknowledge) begin
                  if (cmdWord[DIR_BIT]) begin
                     inWord <= busIn;
                  end
                  dataOutputAvailable <= 1'b0;
                  dataInputRequest <= 1'b0;
                  busOe <= 1'b0;
                  state <= S_DAT_DROP;
               end else if (expired) begin
                  dataOutputAvailable <= 1'b0;
                  dataInputRequest <= 1'b0;
                  busOe <= 1'b0;
                  timedOut <= 1'b1;
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= S_IDLE;
               end
            end
            S_DAT_DROP: begin
               if (!acknowledge) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule

// File: test/pioh_master_monitor.sv
// Port checker for the programmed IO bus master
`timescale 1ns/1ps
module pioh_master_monitor
   import pioh_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [23:0] busOut,
   input wire logic busOe,
   input wire logic commandStrobe,
   input wire logic dataOutputAvailable,
   input wire logic dataInputRequest,
   input wire logic acknowledge,
   input wire logic [23:0] interruptRequestLine,
   input wire logic systemClear,
   input wire logic offlineInhibit,
   input wire logic interruptPending
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_cmdUp; $rose(commandStrobe); endsequence
   sequence s_datUp; $rose(dataOutputAvailable || dataInputRequest); endsequence
   sequence s_busHeld; busOe && $past(busOe, 2) && busOut == $past(busOut, 2); endsequence
   property p_cmdSettle; s_cmdUp |-> s_busHeld; endproperty
   a_cmdSettle: assert property (p_cmdSettle) else $error("command strobe early");
   property p_outSettle; $rose(dataOutputAvailable) |-> s_busHeld; endproperty
   a_outSettle: assert property (p_outSettle) else $error("output strobe early");
   property p_inReq; dataInputRequest |-> !busOe; endproperty
   a_inReq: assert property (p_inReq) else $error("bus driven on input");
   property p_cmdDrop; commandStrobe && acknowledge |=> !commandStrobe && !busOe; endproperty
   a_cmdDrop: assert property (p_cmdDrop) else $error("command not released");
   property p_datDrop;
      (dataOutputAvailable || dataInputRequest) && acknowledge
         |=> !dataOutputAvailable && !dataInputRequest;
   endproperty
   a_datDrop: assert property (p_datDrop) else $error("data strobe held");
   property p_order; s_datUp |-> !commandStrobe && !acknowledge; endproperty
   a_order: assert property (p_order) else $error("data before command done");
   property p_clear;
      systemClear |=> !commandStrobe && !dataOutputAvailable && !dataInputRequest && !busOe;
   endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");
   property p_offline;
      offlineInhibit && $past(offlineInhibit) && $past(offlineInhibit, 2) |-> !interruptPending;
   endproperty
   a_offline: assert property (p_offline) else $error("request while offline");
   property p_pend;
      (|interruptRequestLine && !offlineInhibit && !systemClear) [*3] |-> interruptPending;
   endproperty
   a_pend: assert property (p_pend) else $error("request not seen");
   property p_rdHigh; pready |-> prdata[31:24] == 8'h00; endproperty
   a_rdHigh: assert property (p_rdHigh) else $error("high read bits set");
endmodule
bind pioh_master pioh_master_monitor u_mon (.clk(clk), .srst(srst), .prdata(prdata),
   .pready(pready), .busOut(busOut), .busOe(busOe), .commandStrobe(commandStrobe),
   .dataOutputAvailable(dataOutputAvailable), .dataInputRequest(dataInputRequest),
   .acknowledge(acknowledge), .interruptRequestLine(interruptRequestLine),
   .systemClear(systemClear), .offlineInhibit(offlineInhibit),
   .interruptPending(interruptPending));

// File: test/pioh_sync_model.sv
// Behavioural device synchronizer on the far side of the bus
`timescale 1ns/1ps
module pioh_sync_model
   import pioh_pkg::*;
(
   input wire logic clk,
   input wire logic busOe,
   input wire logic [23:0] busOut,
   input wire logic cStb,
   input wire logic oStb,
   input wire logic iStb,
   input wire logic [7:0] myAddr,
   input wire logic [23:0] rdWord,
   input wire logic [1:0] refuse,
   input wire logic mute,
   input wire logic [3:0] lag,
   output logic ack,
   output logic command_refused,
   output logic [23:0] busIn,
   output logic [23:0] lastCmd,
   output logic [23:0] lastOut
);
   logic [3:0] n = 0;
   logic drv = 0;
   logic [23:0] held = 0;
   wire stb = cStb | oStb | iStb;
   initial begin
      ack = 0;
      command_refused = 0;
   end
   // Released bus toggles so stale data never looks valid
   assign busIn = (busOe === 1'b1) ? busOut : drv ? rdWord : ~held;
   always @(posedge clk) begin
      held <= busIn;
      n <= stb ? n + 4'h1 : 4'h0;
      if (!stb) begin
         ack <= 0;
         command_refused <= 0;
         drv <= 0;
      end else if (n == lag && !ack) begin
         if (cStb && busOut[23:16] == myAddr) begin
            lastCmd <= busOut;
            ack <= 1;
            command_refused <= refuse[0];
         end else if (oStb && !mute) begin
            lastOut <= busOut;
            ack <= 1;
            command_refused <= refuse[1];
         end else if (iStb && !mute) begin
            drv <= 1;
            ack <= 1;
            command_refused <= refuse[1];
         end
      end
   end
endmodule

// File: test/programmed_io_bus_handshake_tb_top.sv
// Self-checking bench for the programmed IO bus master
`timescale 1ns/1ps
module programmed_io_bus_handshake_tb_top;
   import pioh_pkg::*;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, mute = 0, se;
   logic pready, pslverr, busOe, cStb, oStb, iStb, ack, command_refused, sysClr, offl, pend;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rv;
   logic [23:0] busIn, busOut, lastCmd, lastOut, rdWord = 0, lines = 0;
   logic [1:0] refuse = 0;
   logic [3:0] lag = 0;
   int error_cnt = 0, checks_done = 0, cyc = 0;
   always #2.5 clk = ~clk;
   pioh_master #(.TIMEOUT(20)) uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busIn(busIn), .busOut(busOut), .busOe(busOe),
      .commandStrobe(cStb), .dataOutputAvailable(oStb), .dataInputRequest(iStb),
      .acknowledge(ack), .commandRefused(command_refused), .interruptRequestLine(lines),
      .systemClear(sysClr), .offlineInhibit(offl), .interruptPending(pend));
   pioh_sync_model sync (.clk(clk), .busOe(busOe), .busOut(busOut), .cStb(cStb),
      .oStb(oStb), .iStb(iStb), .myAddr(8'h05), .rdWord(rdWord), .refuse(refuse),
      .mute(mute), .lag(lag), .ack(ack), .command_refused(command_refused), .busIn(busIn), .lastCmd(lastCmd),
      .lastOut(lastOut));
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rv = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   function automatic logic [23:0] cw(input logic [7:0] a, input logic d, c,
      input logic [12:0] op);
      return {a, 1'b0, c, d, op};
   endfunction
   task automatic run(input logic [23:0] c, input logic [31:0] st);
      int k = 0;
      apb(1, ADDR_CMD, {8'h00, c});
      do begin
         apb(0, ADDR_STATUS, 0);
         k++;
      end while (rv[0] !== 1'b0 && k < 60);
      chk("status", rv, st);
   endtask
   task automatic t_ops();
      logic [23:0] c;
      for (int k = 0; k < 6; k++) begin
         lag <= 4'(k * 2);
         c = cw(8'h05, 1'b1, 1'b0, 13'(k + 1));
         run(c, 32'h2);
         chk("cmd", {8'h0, lastCmd}, {8'h0, c});
      end
      lag <= 0;
      $display("ops end");
   endtask
   task automatic t_data();
      apb(1, ADDR_WDATA, 32'hff123456);
      run(cw(8'h05, 1'b0, 1'b1, 13'h2), 32'h2);
      chk("out", {8'h0, lastOut}, 32'h123456);
      rdWord <= 24'habcdef;
      refuse <= 2'b10;
      run(cw(8'h05, 1'b1, 1'b1, 13'h3), 32'h2);
      apb(0, ADDR_RDATA, 0);
      chk("in", rv, 32'habcdef);
      refuse <= 2'b01;
      apb(1, ADDR_WDATA, 32'h111111);
      run(cw(8'h05, 1'b0, 1'b1, 13'h2), 32'h6);
      chk("out", {8'h0, lastOut}, 32'h123456);
      refuse <= 0;
      $display("data end");
   endtask
   task automatic t_fault();
      run(cw(8'h06, 1'b0, 1'b0, 13'h1), 32'ha);
      mute <= 1;
      run(cw(8'h05, 1'b0, 1'b1, 13'h2), 32'ha);
      mute <= 0;
      apb(1, ADDR_CTRL, 32'h2);
      apb(0, ADDR_STATUS, 0);
      chk("clr", rv, 0);
      apb(1, ADDR_CTRL, 0);
      apb(0, 8'h20, 0);
      chk("err", {31'h0, se}, 1);
      $display("fault end");
   endtask
   task automatic t_irq();
      lines <= 24'h000008;
      apb(0, ADDR_INTREQ, 0);
      chk("req", rv, 32'h8);
      apb(0, ADDR_STATUS, 0);
      chk("pend", rv, 32'h10);
      apb(1, ADDR_CTRL, 1);
      apb(0, ADDR_STATUS, 0);
      chk("off", rv, 0);
      apb(0, ADDR_INTREQ, 0);
      chk("offreq", rv, 0);
      apb(1, ADDR_CTRL, 0);
      lines <= 0;
      $display("irq end");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      srst <= 0;
      t_ops();
      t_data();
      t_fault();
      t_irq();
      results();
   end
endmodule
